// File: verilog/vtoa_defs.vh
// Constants of the two-source vector lane ALU: register map, fields, opcodes.
// Assumes inclusion by its bare name from the design file.
`ifndef VTOA_DEFS_VH
`define VTOA_DEFS_VH
// ==================================================
// Register map (byte addresses)
`define VTOA_OFF_CTRL 8'h00
`define VTOA_OFF_FIRST_SOURCE_FIELD 8'h04
`define VTOA_OFF_SRC1 8'h08
`define VTOA_OFF_SRC2 8'h0C
`define VTOA_OFF_DEST 8'h10
`define VTOA_OFF_STAT 8'h14
// ==================================================
// Fields
`define VTOA_CTRL_EXEC 16
`define VTOA_CTRL_VCC 17
`define VTOA_STAT_VCC 0
`define VTOA_STAT_PAIR 1
`define VTOA_STAT_DONE 2
`define VTOA_STAT_BAD 3
`define VTOA_RST_WORD 32'h0000_0000
`define VTOA_RESP_OKAY 2'h0
`define VTOA_RESP_SLVERR 2'h2
// ==================================================
// Opcodes
`define VTOA_OP_HALF_ADD 10'h01F
`define VTOA_OP_SINGLE_ADD 10'h101
`define VTOA_OP_ADD_CO 10'h019
`define VTOA_OP_ADD_CO3 10'h119
`define VTOA_OP_ADD_CI 10'h01C
`define VTOA_OP_ADD_CI3 10'h11C
`define VTOA_OP_AND3 10'h113
`define VTOA_OP_ASHR_HALF 10'h02C
`define VTOA_OP_ASHR_WORD 10'h011
`define VTOA_OP_ASHR_WORD3 10'h111
`define VTOA_OP_SELECT 10'h000
`define VTOA_OP_SELECT3 10'h100
`define VTOA_OP_LDEXP_HALF 10'h033
`define VTOA_OP_SHL_HALF 10'h02A
`define VTOA_OP_SHL_WORD 10'h012
`define VTOA_OP_SHL_WORD3 10'h112
`define VTOA_OP_LSHR_HALF 10'h02B
`define VTOA_OP_LSHR_WORD 10'h010
`define VTOA_OP_LSHR_WORD3 10'h116
`define VTOA_OP_HALF_MAC 10'h023
`define VTOA_OP_SINGLE_MAC 10'h016
`define VTOA_OP_SINGLE_MAC3 10'h110
`define VTOA_OP_HALF_MADD_K 10'h025
// ==================================================
// Float constants
`define VTOA_QNAN 32'h7FC0_0000
`define VTOA_F32_BIAS 18'h0_007F
`define VTOA_F16_REBIAS 18'h0_0070
`define VTOA_EXP_MAX 18'h0_00FF
`define VTOA_H16_EXP_MAX 18'h0_001F
`endif

// File: verilog/vtoa_alu.v
// One lane of the two-source vector ALU behind an AXI4-Lite register slave.
// Assumes one clock mclk, async active-high rst, and a well-behaved AXI4-Lite master.
// What this block does
// RULE_01 - Opcode 31 adds two half floats
// RULE_02 - Opcode 257 adds two single floats
// RULE_03 - Opcode 25 integer add, carry to mask
// RULE_04 - Opcode 281 carry goes to scalar pair
// RULE_05 - Opcodes 28/284 add with carry in
// RULE_06 - Opcode 275 bitwise AND, no modifiers
// RULE_07 - Opcode 44 arithmetic right shift, 16 bit
// RULE_08 - Opcodes 17/273 arithmetic right shift, 32 bit
// RULE_09 - Opcodes 0/256 select by mask bit
// RULE_10 - Opcode 51 half float times two-power
// RULE_11 - Opcode 42 left shift, 16 bit
// RULE_12 - Opcodes 18/274 left shift, 32 bit
// RULE_13 - Opcode 43 logical right shift, 16 bit
// RULE_14 - Opcodes 16/278 logical right shift, 32 bit
// RULE_15 - Opcode 35 half multiply-accumulate into destination
// RULE_16 - Opcodes 22/272 single multiply-accumulate
// RULE_17 - Opcode 37 half multiply plus literal
// RULE_18 - Issuer encodes instruction fields and literal
// RULE_19 - Inactive lane keeps destination unchanged
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "vtoa_defs.vh"
module vtoa_alu (
    input wire mclk,
    input wire rst,
    input wire [7:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready
);
    // ==================================================
    // Float helpers (truncating)
    function [31:0] fPack;
        input s;
        input [17:0] e;
        input [22:0] m;
        begin
            if ($signed(e) <= 0)
                fPack = {s, 31'h0000_0000};
            else if (e >= `VTOA_EXP_MAX)
                fPack = {s, 8'hFF, 23'h00_0000};
            else
                fPack = {s, e[7:0], m};
        end
    endfunction

    function [31:0] h2f;
        input [15:0] h;
        integer i;
        integer p;
        reg [22:0] mm;
        reg [7:0] pe;
        begin
            p = 0;
            for (i = 0; i < 10; i = i + 1) begin
                if (h[i])
                    p = i;
            end
            pe = p[7:0] + 8'h67;
            mm = {13'h0000, h[9:0]} << (23 - p);
            if (h[14:10] == 5'h1F)
                h2f = {h[15], 8'hFF, h[9:0], 13'h0000};
            else if (h[14:0] == 15'h0000)
                h2f = {h[15], 31'h0000_0000};
            else if (h[14:10] == 5'h00)
                h2f = {h[15], pe, mm};
            else
                h2f = {h[15], {3'h0, h[14:10]} + 8'h70, h[9:0], 13'h0000};
        end
    endfunction

    function [15:0] f2h;
        input [31:0] f;
        reg [17:0] e;
        reg [10:0] m;
        begin
            e = {10'h000, f[30:23]} - `VTOA_F16_REBIAS;
            m = {1'h1, f[22:13]} >> (18'h0_0001 - e);
            if (f[30:23] == 8'hFF)
                f2h = {f[31], 5'h1F, (f[22:0] != 23'h00_0000), 9'h000};
            else if (f[30:23] == 8'h00)
                f2h = {f[31], 15'h0000};
            else if (!e[17] && e >= `VTOA_H16_EXP_MAX)
                f2h = {f[31], 5'h1F, 10'h000};
            else if (e[17] || e == 18'h0_0000)
                f2h = {f[31], 5'h00, m[9:0]};
            else
                f2h = {f[31], e[4:0], f[22:13]};
        end
    endfunction

    function [31:0] fAdd;
        input [31:0] a;
        input [31:0] b;
        reg [31:0] x;
        reg [31:0] y;
        reg [7:0] d;
        reg [26:0] mx;
        reg [26:0] my;
        reg [26:0] s;
        reg [17:0] e;
        integer i;
        integer lz;
        begin
            if (a[30:0] >= b[30:0]) begin
                x = a;
                y = b;
            end else begin
                x = b;
                y = a;
            end
            d = x[30:23] - y[30:23];
            mx = {2'h1, x[22:0], 2'h0};
            my = (y[30:23] == 8'h00) ? 27'h000_0000 : ({2'h1, y[22:0], 2'h0} >> d);
            s = (x[31] == y[31]) ? mx + my : mx - my;
            e = {10'h000, x[30:23]};
            lz = 0;
            for (i = 0; i < 26; i = i + 1) begin
                if (s[i])
                    lz = 25 - i;
            end
            if (x[30:23] == 8'hFF) begin
                if (y[30:23] == 8'hFF && x[31] != y[31])
                    fAdd = `VTOA_QNAN;
                else
                    fAdd = x | {9'h000, (x[22:0] != 23'h00_0000), 22'h00_0000};
            end else if (x[30:23] == 8'h00 || s == 27'h000_0000)
                fAdd = 32'h0000_0000;
            else if (s[26])
                fAdd = fPack(x[31], e + 18'h0_0001, s[25:3]);
            else begin
                s = s << lz;
                fAdd = fPack(x[31], e - lz[17:0], s[24:2]);
            end
        end
    endfunction

    function [31:0] fMul;
        input [31:0] a;
        input [31:0] b;
        reg [47:0] p;
        reg [17:0] e;
        reg s;
        begin
            s = a[31] ^ b[31];
            p = {1'h1, a[22:0]} * {1'h1, b[22:0]};
            e = {10'h000, a[30:23]} + {10'h000, b[30:23]} - `VTOA_F32_BIAS;
            if ((a[30:23] == 8'hFF && a[22:0] != 23'h00_0000) || (b[30:23] == 8'hFF && b[22:0] != 23'h00_0000))
                fMul = `VTOA_QNAN;
            else if (a[30:23] == 8'hFF || b[30:23] == 8'hFF)
                fMul = (a[30:23] == 8'h00 || b[30:23] == 8'h00) ? `VTOA_QNAN : {s, 8'hFF, 23'h00_0000};
            else if (a[30:23] == 8'h00 || b[30:23] == 8'h00)
                fMul = {s, 31'h0000_0000};
            else if (p[47])
                fMul = fPack(s, e + 18'h0_0001, p[46:24]);
            else
                fMul = fPack(s, e, p[45:23]);
        end
    endfunction

    function [31:0] fLdexp;
        input [31:0] a;
        input [15:0] k;
        begin
            if (a[30:23] == 8'h00 || a[30:23] == 8'hFF)
                fLdexp = a;
            else
                fLdexp = fPack(a[31], {10'h000, a[30:23]} + {{2{k[15]}}, k}, a[22:0]);
        end
    endfunction

    // ==================================================
    // State
    reg awHeldFf, wHeldFf, goFf, execFf, vccFf, pairFf, doneFf, badFf;
    reg [7:0] awAddrFf;
    reg [31:0] wDataFf, src0Ff, src1Ff, src2Ff, destFf;
    reg [3:0] wStrbFf;
    reg [9:0] opFf;
    reg [31:0] nxt_dest;
    reg nxt_bad, nxt_vcc, nxt_pair, vccWe, pairWe, cin;
    reg [32:0] sum;
    reg [31:0] rdMux;
    reg rdOk;
    wire [31:0] wMask;
    wire [7:0] wAddr = {awAddrFf[7:2], 2'h0};
    wire [7:0] rAddr = {araddr[7:2], 2'h0};
    wire doWrite = awHeldFf && wHeldFf && !bvalid;
    wire wrCtrl = doWrite && wAddr == `VTOA_OFF_CTRL;
    wire [31:0] ctrlView = {22'h00_0000, opFf} | ({31'h0000_0000, execFf} << `VTOA_CTRL_EXEC)
                         | ({31'h0000_0000, vccFf} << `VTOA_CTRL_VCC);
    wire [31:0] statView = ({31'h0000_0000, vccFf} << `VTOA_STAT_VCC) | ({31'h0000_0000, pairFf} << `VTOA_STAT_PAIR)
                         | ({31'h0000_0000, doneFf} << `VTOA_STAT_DONE) | ({31'h0000_0000, badFf} << `VTOA_STAT_BAD);
    wire [31:0] ctrlNew = (ctrlView & ~wMask) | (wDataFf & wMask);

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gStrb
            assign wMask[8*g +: 8] = {8{wStrbFf[g]}};
        end
    endgenerate

    // ==================================================
    // AXI4-Lite slave
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            awready <= 1'h1;
            wready <= 1'h1;
            arready <= 1'h1;
            bvalid <= 1'h0;
            rvalid <= 1'h0;
            bresp <= `VTOA_RESP_OKAY;
            rresp <= `VTOA_RESP_OKAY;
            rdata <= `VTOA_RST_WORD;
            awHeldFf <= 1'h0;
            wHeldFf <= 1'h0;
            awAddrFf <= 8'h00;
            wDataFf <= `VTOA_RST_WORD;
            wStrbFf <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeldFf <= 1'h1;
                awAddrFf <= awaddr;
                awready <= 1'h0;
            end
            if (wvalid && wready) begin
                wHeldFf <= 1'h1;
                wDataFf <= wdata;
                wStrbFf <= wstrb;
                wready <= 1'h0;
            end
            if (doWrite) begin
                awHeldFf <= 1'h0;
                wHeldFf <= 1'h0;
                bvalid <= 1'h1;
                bresp <= (wAddr <= `VTOA_OFF_STAT) ? `VTOA_RESP_OKAY : `VTOA_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'h0;
                awready <= 1'h1;
                wready <= 1'h1;
            end
            if (arvalid && arready) begin
                arready <= 1'h0;
                rvalid <= 1'h1;
                rdata <= rdMux;
                rresp <= rdOk ? `VTOA_RESP_OKAY : `VTOA_RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'h0;
                arready <= 1'h1;
            end
        end
    end

    always @* begin
        rdOk = 1'h1;
        case (rAddr)
            `VTOA_OFF_CTRL: rdMux = ctrlView;
            `VTOA_OFF_FIRST_SOURCE_FIELD: rdMux = src0Ff;
            `VTOA_OFF_SRC1: rdMux = src1Ff;
            `VTOA_OFF_SRC2: rdMux = src2Ff;
            `VTOA_OFF_DEST: rdMux = destFf;
            `VTOA_OFF_STAT: rdMux = statView;
            default: begin
                rdMux = `VTOA_RST_WORD;
                rdOk = 1'h0;
            end
        endcase
    end

    // ==================================================
    // Lane datapath
    always @* begin
        nxt_dest = destFf;
        nxt_bad = 1'h0;
        nxt_vcc = vccFf;
        nxt_pair = pairFf;
        vccWe = 1'h0;
        pairWe = 1'h0;
        // RULE_05 carry-in source
        cin = (opFf == `VTOA_OP_ADD_CI3) ? src2Ff[0] : vccFf;
        if (opFf == `VTOA_OP_ADD_CI || opFf == `VTOA_OP_ADD_CI3)
            sum = {1'h0, src0Ff} + {1'h0, src1Ff} + {32'h0000_0000, cin};
        else
            sum = {1'h0, src0Ff} + {1'h0, src1Ff};
        case (opFf)
            // RULE_01 half add
            `VTOA_OP_HALF_ADD: nxt_dest = {16'h0000, f2h(fAdd(h2f(src0Ff[15:0]), h2f(src1Ff[15:0])))};
            // RULE_02 single add
            `VTOA_OP_SINGLE_ADD: nxt_dest = fAdd(src0Ff, src1Ff);
            // RULE_03 carry to mask
            `VTOA_OP_ADD_CO, `VTOA_OP_ADD_CI: begin
                nxt_dest = sum[31:0];
                nxt_vcc = sum[32];
                vccWe = 1'h1;
            end
            // RULE_04 carry to scalar pair
            `VTOA_OP_ADD_CO3, `VTOA_OP_ADD_CI3: begin
                nxt_dest = sum[31:0];
                nxt_pair = sum[32];
                pairWe = 1'h1;
            end
            // RULE_06 plain AND
            `VTOA_OP_AND3: nxt_dest = src0Ff & src1Ff;
            // RULE_07 sign-filled half shift
            `VTOA_OP_ASHR_HALF: nxt_dest = {16'h0000, $signed(src1Ff[15:0]) >>> src0Ff[3:0]};
            // RULE_08 sign-filled word shift
            `VTOA_OP_ASHR_WORD, `VTOA_OP_ASHR_WORD3: nxt_dest = $signed(src1Ff) >>> src0Ff[4:0];
            // RULE_09 mask select
            `VTOA_OP_SELECT: nxt_dest = vccFf ? src1Ff : src0Ff;
            `VTOA_OP_SELECT3: nxt_dest = src2Ff[0] ? src1Ff : src0Ff;
            // RULE_10 exponent load
            `VTOA_OP_LDEXP_HALF: nxt_dest = {16'h0000, f2h(fLdexp(h2f(src0Ff[15:0]), src1Ff[15:0]))};
            // RULE_11 half left shift
            `VTOA_OP_SHL_HALF: nxt_dest = {16'h0000, src1Ff[15:0] << src0Ff[3:0]};
            // RULE_12 word left shift
            `VTOA_OP_SHL_WORD, `VTOA_OP_SHL_WORD3: nxt_dest = src1Ff << src0Ff[4:0];
            // RULE_13 zero-filled half shift
            `VTOA_OP_LSHR_HALF: nxt_dest = {16'h0000, src1Ff[15:0] >> src0Ff[3:0]};
            // RULE_14 zero-filled word shift
            `VTOA_OP_LSHR_WORD, `VTOA_OP_LSHR_WORD3: nxt_dest = src1Ff >> src0Ff[4:0];
            // RULE_15 half accumulate
            `VTOA_OP_HALF_MAC:
                nxt_dest = {16'h0000, f2h(fAdd(fMul(h2f(src0Ff[15:0]), h2f(src1Ff[15:0])), h2f(destFf[15:0])))};
            // RULE_16 single accumulate
            `VTOA_OP_SINGLE_MAC, `VTOA_OP_SINGLE_MAC3: nxt_dest = fAdd(fMul(src0Ff, src1Ff), destFf);
            // RULE_17 literal addend
            `VTOA_OP_HALF_MADD_K:
                nxt_dest = {16'h0000, f2h(fAdd(fMul(h2f(src0Ff[15:0]), h2f(src1Ff[15:0])), h2f(src2Ff[15:0])))};
            default: nxt_bad = 1'h1;
        endcase
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            goFf <= 1'h0;
            opFf <= 10'h000;
            execFf <= 1'h0;
            vccFf <= 1'h0;
            pairFf <= 1'h0;
            doneFf <= 1'h0;
            badFf <= 1'h0;
            src0Ff <= `VTOA_RST_WORD;
            src1Ff <= `VTOA_RST_WORD;
            src2Ff <= `VTOA_RST_WORD;
            destFf <= `VTOA_RST_WORD;
        end else begin
            goFf <= wrCtrl;
            if (wrCtrl) begin
                opFf <= ctrlNew[9:0];
                execFf <= ctrlNew[`VTOA_CTRL_EXEC];
                vccFf <= ctrlNew[`VTOA_CTRL_VCC];
                doneFf <= 1'h0;
            end
            if (doWrite && wAddr == `VTOA_OFF_FIRST_SOURCE_FIELD)
                src0Ff <= (src0Ff & ~wMask) | (wDataFf & wMask);
            if (doWrite && wAddr == `VTOA_OFF_SRC1)
                src1Ff <= (src1Ff & ~wMask) | (wDataFf & wMask);
            if (doWrite && wAddr == `VTOA_OFF_SRC2)
                src2Ff <= (src2Ff & ~wMask) | (wDataFf & wMask);
            if (doWrite && wAddr == `VTOA_OFF_DEST)
                destFf <= (destFf & ~wMask) | (wDataFf & wMask);
            // Hardware result wins over a bus write in the same cycle
            if (goFf) begin
                doneFf <= 1'h1;
                badFf <= nxt_bad;
                // RULE_19 inactive lane holds
                if (execFf && !nxt_bad) begin
                    destFf <= nxt_dest;
                    if (vccWe)
                        vccFf <= nxt_vcc;
                    if (pairWe)
                        pairFf <= nxt_pair;
                end
            end
        end
    end
endmodule // vtoa_alu

// File: verif/vtoa_alu_chk.sv
// Bus-level checker for the vector lane ALU register slave.
// Assumes one clock mclk and async active-high rst.
`timescale 1ns/1ps
module vtoa_alu_chk (
    input wire mclk,
    input wire rst,
    input wire [7:0] awaddr,
    input wire awvalid,
    input wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    input wire arready,
    input wire [31:0] rdata,
    input wire [1:0] rresp,
    input wire rvalid,
    input wire rready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_bHold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_bHold: assert property (p_bHold) else $error("write answer dropped");
    property p_rHold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
    a_rHold: assert property (p_rHold) else $error("read answer changed");
    property p_arBlock; rvalid |-> !arready; endproperty
    a_arBlock: assert property (p_arBlock) else $error("read taken while busy");
    property p_rAns; arvalid && arready |=> rvalid; endproperty
    a_rAns: assert property (p_rAns) else $error("read answer late");
    property p_bAns; awvalid && awready && wvalid && wready |=> ##1 bvalid; endproperty
    a_bAns: assert property (p_bAns) else $error("write answer late");
    property p_wBlock; bvalid |-> !awready && !wready; endproperty
    a_wBlock: assert property (p_wBlock) else $error("write taken while busy");
    property p_bFree; bvalid && bready |=> !bvalid && awready && wready; endproperty
    a_bFree: assert property (p_bFree) else $error("write path not freed");
    property p_rErr; arvalid && arready && araddr[7:2] > 6'h05 |=> rresp == 2'h2 && rdata == 32'h0000_0000;
    endproperty
    a_rErr: assert property (p_rErr) else $error("unmapped read not refused");
    property p_wErr; awvalid && awready && wvalid && wready && awaddr[7:2] > 6'h05 |=> ##1 bresp == 2'h2;
    endproperty
    a_wErr: assert property (p_wErr) else $error("unmapped write not refused");
endmodule // vtoa_alu_chk
bind vtoa_alu vtoa_alu_chk chk_u (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

// File: verif/vtoa_seq_mdl.sv
// Sequencer-side bus master issuing register accesses to the lane ALU.
// Assumes tasks are entered just after a rising edge of mclk.
`timescale 1ns/1ps
module vtoa_seq_mdl (
    input wire mclk,
    input wire awready,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    input wire arready,
    input wire [31:0] rdata,
    input wire [1:0] rresp,
    input wire rvalid,
    output reg [7:0] awaddr = 8'h00,
    output reg awvalid = 1'b0,
    output reg [31:0] wdata = 32'h0000_0000,
    output reg [3:0] wstrb = 4'hf,
    output reg wvalid = 1'b0,
    output reg bready = 1'b0,
    output reg [7:0] araddr = 8'h00,
    output reg arvalid = 1'b0,
    output reg rready = 1'b0
);
    reg tmo = 1'b0;
    task wr(input [7:0] a, input [31:0] d, output [1:0] r);
        integer n;
        reg sa, sw, sb;
        begin
            sb = 0;
            r = 2'h3;
            awaddr <= a;
            wdata <= d;
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
            for (n = 0; n < 40 && !sb; n = n + 1) begin
                @(negedge mclk);
                sa = awready;
                sw = wready;
                sb = bvalid;
                r = bresp;
                @(posedge mclk);
                if (awvalid && sa) begin
                    awvalid <= 0;
                    awaddr <= ~a;
                end
                if (wvalid && sw) begin
                    wvalid <= 0;
                    wdata <= ~d;
                end
            end
            bready <= 0;
            if (!sb) tmo = 1;
            // Idle edge between transfers
            @(posedge mclk);
        end
    endtask
    // Partial write with byte enables
    task wrs(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
        begin
            wstrb <= s;
            wr(a, d, r);
            wstrb <= 4'hf;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        integer n;
        reg sa, sb;
        begin
            sb = 0;
            araddr <= a;
            arvalid <= 1;
            rready <= 1;
            for (n = 0; n < 40 && !sb; n = n + 1) begin
                @(negedge mclk);
                sa = arready;
                sb = rvalid;
                d = rdata;
                r = rresp;
                @(posedge mclk);
                if (arvalid && sa) begin
                    arvalid <= 0;
                    araddr <= ~a;
                end
            end
            rready <= 0;
            if (!sb) tmo = 1;
            // Idle edge between transfers
            @(posedge mclk);
        end
    endtask
endmodule // vtoa_seq_mdl

// File: verif/tb_vtoa_alu.sv
// Self-checking bench for the lane ALU: random integer ops against a model, fixed float cases.
// Assumes the sequencer model drives the register bus.
`timescale 1ns/1ps
module tb_vtoa_alu;
    reg mclk = 0;
    reg rst = 1;
    wire [7:0] awaddr, araddr;
    wire [31:0] wdata, rdata;
    wire [3:0] wstrb;
    wire [1:0] bresp, rresp;
    wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    integer errTotal = 0;
    integer totalChecks = 0;
    integer i, j;
    reg [31:0] seed = 32'h0000_97e0;
    reg [31:0] rv, a, b, c;
    reg [1:0] rs;
    reg [9:0] op;
    reg [32:0] m;
    reg [3:0] ex, mk;
    reg [159:0] opl = {10'h019, 10'h119, 10'h01c, 10'h11c, 10'h113, 10'h02c, 10'h011, 10'h111,
        10'h02a, 10'h012, 10'h112, 10'h02b, 10'h010, 10'h116, 10'h000, 10'h100};
    always #25 mclk = ~mclk;
    vtoa_seq_mdl mst_u (.mclk(mclk), .awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .awaddr(awaddr), .awvalid(awvalid),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .rready(rready));
    vtoa_alu dut_u (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    // Reference lane result with carry on top
    function [32:0] mdl(input [9:0] o, input [31:0] p, input [31:0] q, input [31:0] r, input v);
        reg [15:0] h;
        begin
            h = $signed(q[15:0]) >>> p[3:0];
            case (o)
                10'h019, 10'h119: mdl = {1'b0, p} + q;
                10'h01c: mdl = {1'b0, p} + q + v;
                10'h11c: mdl = {1'b0, p} + q + r[0];
                10'h113: mdl = p & q;
                10'h02c: mdl = {17'h0, h};
                10'h011, 10'h111: mdl = {1'b0, $signed(q) >>> p[4:0]};
                10'h02a: mdl = {17'h0, q[15:0] << p[3:0]};
                10'h012, 10'h112: mdl = {1'b0, q << p[4:0]};
                10'h02b: mdl = {17'h0, q[15:0] >> p[3:0]};
                10'h010, 10'h116: mdl = {1'b0, q >> p[4:0]};
                10'h000: mdl = v ? q : p;
                default: mdl = r[0] ? q : p;
            endcase
        end
    endfunction
    task check(input [31:0] got, input [31:0] exp);
        begin
            totalChecks = totalChecks + 1;
            if (got !== exp) begin
                errTotal = errTotal + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task stopTest;
        begin
            $display("checks %0d mismatches %0d", totalChecks, errTotal);
            if (errTotal == 0 && totalChecks > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task guard;
        begin
            if (mst_u.tmo) begin
                errTotal = errTotal + 1;
                stopTest;
            end
        end
    endtask
    // Load operands, launch, wait for done, compare
    task run(input [9:0] o, input [31:0] p, q, r, d, input v, e, input [31:0] xd, input [3:0] xst, msk);
        begin
            mst_u.wr(8'h04, p, rs);
            mst_u.wr(8'h08, q, rs);
            mst_u.wr(8'h0c, r, rs);
            mst_u.wr(8'h10, d, rs);
            mst_u.wr(8'h00, {14'h0, v, e, 6'h0, o}, rs);
            check({30'h0, rs}, 32'h0);
            rv = 0;
            for (j = 0; j < 8 && !rv[2] && !rv[3]; j = j + 1) mst_u.rd(8'h14, rv, rs);
            check(rv[3:0] & msk, xst);
            mst_u.rd(8'h10, rv, rs);
            check(rv, xd);
            guard;
        end
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        for (i = 0; i < 48; i = i + 1) begin
            op = opl[(15 - i % 16) * 10 +: 10];
            a = xs(seed);
            b = xs(a);
            c = xs(b);
            seed = c;
            m = mdl(op, a, b, c, seed[7]);
            mk = (op == 10'h019 || op == 10'h01c) ? 4'hd : (op == 10'h119 || op == 10'h11c) ? 4'he : 4'hc;
            ex = {2'b01, m[32], m[32]} & mk;
            run(op, a, b, c, 32'h0, seed[7], 1'b1, m[31:0], ex, mk);
        end
        run(10'h01f, 32'h3c00, 32'h3c00, 0, 0, 0, 1, 32'h4000, 4'h4, 4'hc);
        run(10'h101, 32'h3f80_0000, 32'h3f80_0000, 0, 0, 0, 1, 32'h4000_0000, 4'h4, 4'hc);
        run(10'h033, 32'h3c00, 32'h3, 0, 0, 0, 1, 32'h4800, 4'h4, 4'hc);
        run(10'h023, 32'h3c00, 32'h4000, 0, 32'h3c00, 0, 1, 32'h4200, 4'h4, 4'hc);
        run(10'h016, 32'h3f80_0000, 32'h4000_0000, 0, 32'h3f80_0000, 0, 1, 32'h4040_0000, 4'h4, 4'hc);
        run(10'h110, 32'h3f80_0000, 32'h4000_0000, 0, 32'h3f80_0000, 0, 1, 32'h4040_0000, 4'h4, 4'hc);
        run(10'h025, 32'h3c00, 32'h4000, 32'h3c00, 0, 0, 1, 32'h4200, 4'h4, 4'hc);
        run(10'h019, 32'hffff_ffff, 32'h1, 0, 32'h1234_5678, 0, 0, 32'h1234_5678, 4'h4, 4'hd);
        run(10'h3ff, 32'h5, 32'h6, 0, 32'h0bad_0001, 0, 1, 32'h0bad_0001, 4'h8, 4'h8);
        mst_u.wrs(8'h10, 32'haaaa_bbbb, 4'h5, rs);
        mst_u.rd(8'h10, rv, rs);
        check(rv, 32'h0baa_00bb);
        mst_u.wr(8'h20, 32'h1, rs);
        check({30'h0, rs}, 32'h2);
        mst_u.rd(8'h20, rv, rs);
        check(rv, 32'h0);
        check({30'h0, rs}, 32'h2);
        guard;
        stopTest;
    end
endmodule // tb_vtoa_alu
